/* File: include/bit_logic_pkg.sv */
// constants for the bit-logic / call execution block
// assumes a 12-bit instruction word and an 11-bit program counter
package bit_logic_pkg;
   localparam int INSTR_W = 12;
   localparam int PC_W = 11;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   // opcode fields
   localparam int OP4_MSB = 11;
   localparam int OP4_LSB = 8;
   localparam int OP6_LSB = 6;
   localparam int BIT_MSB = 7;
   localparam int BIT_LSB = 5;
   localparam int DEST_POS = 5;
   localparam int FADDR_MSB = 4;
   localparam int LIT_MSB = 7;
   // opcode values
   localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
   localparam logic [3:0] OP_BIT_SET = 4'h5;
   localparam logic [3:0] OP_TEST_CLEAR = 4'h6;
   localparam logic [3:0] OP_TEST_SET = 4'h7;
   localparam logic [3:0] OP_AND_LIT = 4'he;
   localparam logic [3:0] OP_CALL = 4'h9;
   localparam logic [5:0] OP_AND_FILE = 6'h05;
   localparam logic [11:0] OP_CLEAR_ACC = 12'h040;
   // status register page bits, copied to pc bits 10:9
   localparam int STATUS_PAGE_MSB = 6;
   localparam int STATUS_PAGE_LSB = 5;
   // reset values and pc increments
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [10:0] PC_ONE = 11'h001;
   localparam logic [10:0] PC_TWO = 11'h002;

   typedef enum logic [0:0] {
      ST_EXEC = 1'b0,
      ST_FLUSH = 1'b1
   } exec_state_t;

   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction : bit_mask

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == ZERO_BYTE);
   endfunction : is_zero
endpackage : bit_logic_pkg

/* File: hw/file_reg_array.sv */
// 32 x 8 file register array, combinational read, clocked write
// assumes write enable already qualified by the clock enable
module file_reg_array
   import bit_logic_pkg::*;
(
   input wire logic clk,
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [4:0] raddr,
   output logic [7:0] rdata
);
   // contents are left unreset, as in ordinary data memory
   logic [7:0] mem [0:31];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule : file_reg_array

/* File: hw/bit_logic_call_execute.sv */
// execution of bit set/clear, bit test-skip, and, clear-acc and call
// assumes instr_word holds the word at program_counter in each exec cycle
// Notes on behaviour
// - bit clear forces bit b of file f to zero, flags untouched
// - bit set forces bit b of file f to one, flags untouched
// - and-literal ands accumulator with 8-bit literal into accumulator, updates zero
// - and-file ands accumulator with file; dest 0 accumulator, 1 file; updates zero
// - test-skip-clear skips next instruction when bit reads 0, no flag change
// - test-skip-set skips next instruction when bit reads 1, no flag change
// - a taken skip discards the prefetched word and runs a no-op instead
// - clear-accumulator loads 00h and sets the zero flag
// - call first pushes program counter plus one onto the return stack
// - call loads its 8-bit literal into program counter bits 7:0
// - call copies status bits 6:5 to counter bits 10:9, clears bit 8
// - call takes two cycles and changes no status flag
module bit_logic_call_execute
   import bit_logic_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [11:0] instr_word,
   input wire logic [7:0] status_reg,
   output logic [10:0] program_counter,
   output logic [7:0] accumulator,
   output logic zero_flag,
   output logic squash,
   output logic push_valid,
   output logic [10:0] push_addr,
   output logic file_wr_en,
   output logic [4:0] file_wr_addr,
   output logic [7:0] file_wr_data
);
   typedef struct packed {
      exec_state_t state;
      logic [10:0] pc;
      logic [7:0] acc;
      logic zero;
      logic push_valid;
      logic [10:0] push_addr;
      logic wr_en;
      logic [4:0] wr_addr;
      logic [7:0] wr_data;
   } core_t;

   core_t st_r;
   core_t st_nxt;

   logic [3:0] op4;
   logic [5:0] op6;
   logic [2:0] bsel;
   logic [4:0] faddr;
   logic [7:0] lit;
   logic dest_file;
   logic [7:0] file_q;
   logic [7:0] mask;
   logic tested_bit;
   logic executing;

   assign op4 = instr_word[OP4_MSB:OP4_LSB];
   assign op6 = instr_word[OP4_MSB:OP6_LSB];
   assign bsel = instr_word[BIT_MSB:BIT_LSB];
   assign faddr = instr_word[FADDR_MSB:0];
   assign lit = instr_word[LIT_MSB:0];
   assign dest_file = instr_word[DEST_POS];
   assign mask = bit_mask(bsel);
   assign tested_bit = |(file_q & mask);
   assign executing = (st_r.state == ST_EXEC);

   // reset also blocks array writes: st_nxt is only meaningful once released
   file_reg_array u_files (
      .clk(clk),
      .we(ce & resetn & st_nxt.wr_en),
      .waddr(st_nxt.wr_addr),
      .wdata(st_nxt.wr_data),
      .raddr(faddr),
      .rdata(file_q)
   );

   always_comb begin
      logic [7:0] and_res;
      and_res = ZERO_BYTE;
      st_nxt = st_r;
      st_nxt.push_valid = 1'b0;
      st_nxt.wr_en = 1'b0;
      st_nxt.state = ST_EXEC;
      st_nxt.pc = st_r.pc + PC_ONE;
      unique case (st_r.state)
         // flush cycle: prefetched word ignored, acts as no-op
         ST_FLUSH: begin
            st_nxt.pc = st_r.pc;
         end
         ST_EXEC: begin
            if (op4 == OP_BIT_CLEAR) begin
               st_nxt.wr_en = 1'b1;
               st_nxt.wr_addr = faddr;
               st_nxt.wr_data = file_q & ~mask;
            end else if (op4 == OP_BIT_SET) begin
               st_nxt.wr_en = 1'b1;
               st_nxt.wr_addr = faddr;
               st_nxt.wr_data = file_q | mask;
            end else if ((op4 == OP_TEST_CLEAR && !tested_bit) ||
                         (op4 == OP_TEST_SET && tested_bit)) begin
               // skip: discard next word, resume two on
               st_nxt.state = ST_FLUSH;
               st_nxt.pc = st_r.pc + PC_TWO;
            end else if (op4 == OP_AND_LIT) begin
               and_res = st_r.acc & lit;
               st_nxt.acc = and_res;
               st_nxt.zero = is_zero(and_res);
            end else if (op6 == OP_AND_FILE) begin
               and_res = st_r.acc & file_q;
               st_nxt.zero = is_zero(and_res);
               if (dest_file) begin
                  st_nxt.wr_en = 1'b1;
                  st_nxt.wr_addr = faddr;
                  st_nxt.wr_data = and_res;
               end else begin
                  st_nxt.acc = and_res;
               end
            end else if (instr_word == OP_CLEAR_ACC) begin
               st_nxt.acc = ACC_RESET;
               st_nxt.zero = 1'b1;
            end else if (op4 == OP_CALL) begin
               st_nxt.push_valid = 1'b1;
               st_nxt.push_addr = st_r.pc + PC_ONE;
               // build target from page bits and literal
               st_nxt.pc = {status_reg[STATUS_PAGE_MSB:STATUS_PAGE_LSB], 1'b0, lit};
               // second cycle is a flush, flags untouched
               st_nxt.state = ST_FLUSH;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '{state: ST_EXEC, pc: PC_RESET, acc: ACC_RESET, zero: 1'b0,
                   push_valid: 1'b0, push_addr: PC_RESET, wr_en: 1'b0,
                   wr_addr: 5'h00, wr_data: ZERO_BYTE};
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign program_counter = st_r.pc;
   assign accumulator = st_r.acc;
   assign zero_flag = st_r.zero;
   assign squash = (st_r.state == ST_FLUSH);
   assign push_valid = st_r.push_valid;
   assign push_addr = st_r.push_addr;
   assign file_wr_en = st_r.wr_en;
   assign file_wr_addr = st_r.wr_addr;
   assign file_wr_data = st_r.wr_data;

   sequence s_call;
      ce && executing && op4 == OP_CALL;
   endsequence
   sequence s_skip;
      ce && executing && ((op4 == OP_TEST_CLEAR && !tested_bit) ||
                          (op4 == OP_TEST_SET && tested_bit));
   endsequence

   a_bit_clear: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && op4 == OP_BIT_CLEAR |=> file_wr_en &&
      file_wr_data == ($past(file_q) & ~$past(mask)) && zero_flag == $past(zero_flag))
      else $error("bit clear result wrong");
   a_bit_set: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && op4 == OP_BIT_SET |=> file_wr_en &&
      file_wr_addr == $past(faddr) && file_wr_data[$past(bsel)] && zero_flag == $past(zero_flag))
      else $error("bit set result wrong");
   a_and_lit: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && op4 == OP_AND_LIT |=>
      accumulator == ($past(accumulator) & $past(lit)))
      else $error("and literal result wrong");
   a_and_file_dest: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && op6 == OP_AND_FILE && dest_file |=> file_wr_en &&
      file_wr_data == ($past(accumulator) & $past(file_q)) && $stable(accumulator))
      else $error("and file destination wrong");
   a_skip_taken: assert property (@(posedge clk) disable iff (!resetn)
      s_skip |=> squash && program_counter == $past(program_counter) + PC_TWO &&
      $stable(zero_flag) ##1 (!$past(ce) || !squash))
      else $error("skip did not squash one word");
   a_no_skip: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && op4 == OP_TEST_CLEAR && tested_bit |=> !squash && $stable(zero_flag))
      else $error("test clear skipped on set bit");
   a_clear_acc: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && instr_word == OP_CLEAR_ACC |=> accumulator == ZERO_BYTE && zero_flag)
      else $error("clear accumulator wrong");
   a_call_push: assert property (@(posedge clk) disable iff (!resetn)
      s_call |=> push_valid && push_addr == $past(program_counter) + PC_ONE)
      else $error("call push address wrong");
   a_call_target: assert property (@(posedge clk) disable iff (!resetn)
      s_call |=> program_counter == {$past(status_reg[6:5]), 1'b0, $past(lit)})
      else $error("call target wrong");
   a_call_two: assert property (@(posedge clk) disable iff (!resetn)
      s_call |=> squash && $stable(zero_flag))
      else $error("call not two cycles");
   a_zero_track: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && (op4 == OP_AND_LIT || op6 == OP_AND_FILE) |=>
      zero_flag == ((file_wr_en ? file_wr_data : accumulator) == ZERO_BYTE))
      else $error("zero flag wrong");
   a_no_skip_set: assert property (@(posedge clk) disable iff (!resetn)
      ce && executing && op4 == OP_TEST_SET && !tested_bit |=> !squash && $stable(zero_flag))
      else $error("test set skipped on clear bit");
   a_flush_idle: assert property (@(posedge clk) disable iff (!resetn)
      ce && squash |=> !squash && !push_valid && !file_wr_en && $stable(accumulator))
      else $error("discarded word had an effect");
   a_call_low: assert property (@(posedge clk) disable iff (!resetn)
      s_call |=> program_counter[7:0] == $past(lit) && !program_counter[8])
      else $error("call literal not loaded");
   a_hold_off: assert property (@(posedge clk) disable iff (!resetn)
      !ce |=> $stable(program_counter) && $stable(accumulator) && $stable(squash))
      else $error("state moved while clock enable low");
endmodule : bit_logic_call_execute

/* File: bench/bit_logic_call_execute_tb.sv */
// self-checking bench for the bit-logic / call execution block
// assumes the block's file array is reachable only through its write outputs
module bit_logic_call_execute_tb
   import bit_logic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [10:0] pcv;
      logic [7:0] acc;
      logic z, sq, pv;
      logic [10:0] pa;
      logic we;
      logic [4:0] wa;
      logic [7:0] wd;
   } exp_t;
   logic clk, resetn, ce, zero_flag, squash, push_valid, file_wr_en;
   logic [11:0] instr_word;
   logic [7:0] status_reg, accumulator, file_wr_data;
   logic [10:0] program_counter, push_addr;
   logic [4:0] file_wr_addr;
   int err_count = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'h0000_0047;
   logic [7:0] files [0:31];
   exp_t last;
   exp_t q[$];
   bit_logic_call_execute bit_logic_call_execute_i (.clk(clk), .resetn(resetn), .ce(ce),
      .instr_word(instr_word), .status_reg(status_reg), .program_counter(program_counter),
      .accumulator(accumulator), .zero_flag(zero_flag), .squash(squash),
      .push_valid(push_valid), .push_addr(push_addr), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));
   always #5 clk = ~clk;
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic cmp_now(input exp_t e);
      exp_t o;
      o = {program_counter, accumulator, zero_flag, squash, push_valid, push_addr,
           file_wr_en, file_wr_addr, file_wr_data};
      // address and data only mean something alongside their strobe
      if (e.pv !== 1'b1) o.pa = e.pa;
      if (e.we !== 1'b1) {o.wa, o.wd} = {e.wa, e.wd};
      n_tests++;
      if (o !== e) begin
         $display("unexpected state expected %h seen %h", e, o);
         err_count++;
      end
   endtask : cmp_now
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic do_reset(input int n);
      @(negedge clk);
      resetn = 1'b0;
      ce = 1'b0;
      repeat (n) @(negedge clk);
      last = '0;
      cmp_now(last);
      resetn = 1'b1;
   endtask : do_reset
   // reference model: one entry per issued word, checked after the next edge
   task automatic issue(input logic [11:0] w, input logic c);
      exp_t e;
      logic [31:0] st;
      logic [7:0] fv, r;
      logic [4:0] f;
      logic [2:0] b;
      @(negedge clk);
      st = xs();
      instr_word = w;
      ce = c;
      status_reg = st[7:0];
      e = last;
      f = w[4:0];
      b = w[7:5];
      fv = files[f];
      if (c && last.sq) begin
         {e.sq, e.pv, e.we} = 3'b000;
      end else if (c) begin
         {e.pv, e.we} = 2'b00;
         e.pcv = last.pcv + 11'h001;
         case (w[11:8])
            OP_BIT_CLEAR, OP_BIT_SET: begin
               r = w[8] ? (fv | (8'h01 << b)) : (fv & ~(8'h01 << b));
               files[f] = r;
               {e.we, e.wa, e.wd} = {1'b1, f, r};
            end
            OP_TEST_CLEAR, OP_TEST_SET: begin
               if (fv[b] == w[8]) {e.sq, e.pcv} = {1'b1, last.pcv + 11'h002};
            end
            OP_AND_LIT: {e.acc, e.z} = {last.acc & w[7:0], (last.acc & w[7:0]) == 8'h00};
            OP_CALL: begin
               {e.pv, e.pa, e.sq} = {1'b1, last.pcv + 11'h001, 1'b1};
               e.pcv = {st[6:5], 1'b0, w[7:0]};
            end
            default: begin
               r = last.acc & fv;
               if (w[11:6] == OP_AND_FILE) begin
                  e.z = (r == 8'h00);
                  if (w[5]) begin
                     files[f] = r;
                     {e.we, e.wa, e.wd} = {1'b1, f, r};
                  end else e.acc = r;
               end else if (w == OP_CLEAR_ACC) {e.acc, e.z} = {8'h00, 1'b1};
            end
         endcase
      end
      q.push_back(e);
      last = e;
   endtask : issue
   function automatic logic [11:0] rand_word(input logic [31:0] r);
      logic [3:0] ops [0:5];
      ops = '{OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_CLEAR, OP_TEST_SET, OP_AND_LIT, OP_CALL};
      case (r[15:12] % 9)
         0, 1, 2, 3, 4, 5: return {ops[r[15:12] % 9], r[7:0]};
         6: return {OP_AND_FILE, r[5:0]};
         7: return OP_CLEAR_ACC;
         default: return 12'h000;
      endcase
   endfunction : rand_word
   always @(posedge clk) begin
      #1;
      if (q.size() > 0) cmp_now(q.pop_front());
   end
   initial begin
      #200000;
      err_count++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial begin
      logic [31:0] r;
      {clk, resetn, ce, instr_word, status_reg} = '0;
      do_reset(4);
      issue({OP_AND_LIT, 8'hff}, 1'b1);
      issue(OP_CLEAR_ACC, 1'b1);
      // and with a cleared accumulator zeroes every file register
      for (int i = 0; i < 32; i++) issue({OP_AND_FILE, 1'b1, 5'(i)}, 1'b1);
      $display("test init done");
      issue({OP_BIT_SET, 3'h7, 5'h1f}, 1'b1);
      issue({OP_TEST_SET, 3'h7, 5'h1f}, 1'b1);
      issue({OP_BIT_SET, 3'h0, 5'h00}, 1'b1);
      issue({OP_TEST_CLEAR, 3'h7, 5'h1f}, 1'b1);
      issue({OP_BIT_CLEAR, 3'h7, 5'h1f}, 1'b1);
      issue({OP_TEST_CLEAR, 3'h7, 5'h1f}, 1'b1);
      issue({OP_BIT_SET, 3'h0, 5'h00}, 1'b1);
      issue({OP_CALL, 8'ha5}, 1'b1);
      issue({OP_AND_FILE, 1'b0, 5'h00}, 1'b1);
      $display("test directed done");
      repeat (3000) begin
         r = xs();
         issue(rand_word(r), r[31:29] != 3'h0);
      end
      $display("test random done");
      do_reset(2);
      issue({OP_CALL, 8'hff}, 1'b1);
      issue({OP_TEST_SET, 3'h0, 5'h00}, 1'b1);
      issue(12'h000, 1'b1);
      @(negedge clk);
      @(negedge clk);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : bit_logic_call_execute_tb
